// ===== hw/lmcd_defines.svh
// constants for the motion command decoder
`ifndef LMCD_DEFINES_SVH
`define LMCD_DEFINES_SVH
`define LMCD_REG_CTRL 4'h0
`define LMCD_REG_STATUS 4'h4
`define LMCD_REG_PARAM 4'h8
`define LMCD_REG_TARGET 4'hC
`define LMCD_CTRL_NAD_LSB 0
`define LMCD_CTRL_SLEEP_BIT 8
`define LMCD_NAD_RST 8'h01
`define LMCD_SLEEP_ALLOW_RST 1'b1
`define LMCD_DUAL_ID_DEF 6'h05
`define LMCD_PARAM_ID_DEF 6'h00
`define LMCD_SLEEP_ID 6'h3C
`define LMCD_SLEEP_CMD 8'h00
`define LMCD_BCAST_NAD 8'h7F
`define LMCD_CMD_POSPARAM 8'h2F
`define LMCD_SECONDARY_POSITION_OFF 11'h400
`define LMCD_CKSUM_GOOD 8'hFF
`define LMCD_LEN_DUAL 4'h7
`define LMCD_LEN_PARAM 4'h8
`define LMCD_LEN_SLEEP 4'h9
`define LMCD_BUF_DEPTH 9
`define LMCD_D_FIRST_NODE_ADDRESS 0
`define LMCD_D_P1L 1
`define LMCD_D_P1H 2
`define LMCD_D_SECOND_NODE_ADDRESS 3
`define LMCD_D_P2L 4
`define LMCD_D_P2H 5
`define LMCD_P_NAD 0
`define LMCD_P_CMD 1
`define LMCD_P_PL 2
`define LMCD_P_PH 3
`define LMCD_P_VEL 4
`define LMCD_P_THR 5
`define LMCD_S_CMD 0
`endif

// ===== hw/lmcd_pkg.sv
// types shared by the motion command decoder
`default_nettype none
package lmcd_pkg;
  typedef struct packed {
    logic [3:0] vmax;
    logic [3:0] vmin;
    logic [3:0] stall_thr;
    logic [3:0] accel;
  } lmcd_motion_param_type;
  typedef enum logic {LMCD_ST_IDLE, LMCD_ST_HALT} lmcd_state_type;
  typedef enum logic {LMCD_HS_IDLE, LMCD_HS_WAIT} lmcd_halt_state_type;
endpackage
`default_nettype wire

// ===== hw/lmcd_cksum.sv
// running lin checksum with carry fold
`default_nettype none
`include "lmcd_defines.svh"
module lmcd_cksum import lmcd_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [7:0] init,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  output logic ok
);
  logic [7:0] sum_r;
  logic [7:0] sum_nxt;

  function automatic logic [7:0] carry_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return 8'(s[7:0] + {7'h00, s[8]});
  endfunction

  always_comb begin
    sum_nxt = sum_r;
    if (start) begin
      sum_nxt = init;
    end else if (byte_valid) begin
      sum_nxt = carry_add(sum_r, byte_in);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sum_r <= 8'h00;
    end else begin
      sum_r <= sum_nxt;
    end
  end

  // sum over data and checksum byte folds to all ones when intact
  assign ok = (sum_r == `LMCD_CKSUM_GOOD);
endmodule // lmcd_cksum
`default_nettype wire

// ===== hw/lmcd_halt.sv
// gentle halt sequencer: decelerate, wait for standstill, hold position
`default_nettype none
`include "lmcd_defines.svh"
module lmcd_halt import lmcd_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic motion_active,
  input wire logic [15:0] actual_position,
  output logic halt_active,
  output logic done,
  output logic [15:0] hold_position
);
  lmcd_halt_state_type st_r, st_nxt;
  logic done_r, done_nxt;
  logic [15:0] hold_r, hold_nxt;

  always_comb begin
    st_nxt = st_r;
    done_nxt = 1'b0;
    hold_nxt = hold_r;
    unique case (st_r)
      LMCD_HS_IDLE: begin
        if (start) begin
          st_nxt = LMCD_HS_WAIT;
        end
      end
      LMCD_HS_WAIT: begin
        // stop wherever reached, then freeze that spot as target
        if (!motion_active) begin
          st_nxt = LMCD_HS_IDLE;
          done_nxt = 1'b1;
          hold_nxt = actual_position;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= LMCD_HS_IDLE;
      done_r <= 1'b0;
      hold_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      done_r <= done_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign halt_active = (st_r == LMCD_HS_WAIT);
  assign done = done_r;
  assign hold_position = hold_r;

  AST_HALT_DONE: assert property (@(posedge clk) disable iff (srst)
    done |-> $past(halt_active) && hold_position == $past(actual_position))
    else $error("halt done without captured standstill position");
endmodule // lmcd_halt
`default_nettype wire

// ===== hw/lmcd_decoder.sv
// lin motion command decoder: dual goto, goto with params, go to sleep
// Overview of operation
// - dual frame: first_node_address, first_target_position lo/hi, second_node_address, second_target_position lo/hi
// - broadcast slot skipped, other slot still runs
// - targets are signed 16-bit absolute positions
// - drop dual goto when positioning is ignored
// - param frame: node address then code 0x2F
// - load velocities, stall threshold, acceleration
// - signed 16-bit set-point, low byte first
// - accept broadcast 0x7F or own address
// - sleep: id 0x3C, first byte 0x00
// - trailing sleep bytes are not checked
// - sleep applies regardless of node address
// - moving, secondary enabled: target takes secondary
// - moving, secondary disabled: gentle halt first
// - sleep entered only when sleep allowed
// - sleep not allowed: enter stopped state
// - gentle halt stops, target takes actual
//
// Implementation choices: the placing of the registers and the strobed register port.
`default_nettype none
`include "lmcd_defines.svh"
module lmcd_decoder import lmcd_pkg::*; #(
  parameter logic [5:0] DUAL_ID = `LMCD_DUAL_ID_DEF,
  parameter logic [5:0] PARAM_ID = `LMCD_PARAM_ID_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic lnk_frame_start,
  input wire logic [7:0] lnk_pid,
  input wire logic lnk_byte_valid,
  input wire logic [7:0] lnk_byte,
  input wire logic lnk_frame_end,
  input wire logic positioning_ignored,
  input wire logic motion_active,
  input wire logic [15:0] actual_position,
  input wire logic [10:0] secondary_position,
  output logic [15:0] target_position,
  output logic target_load,
  output lmcd_motion_param_type motion_params,
  output logic params_load,
  output logic gentle_halt,
  output logic sleep_enter,
  output logic stopped_enter
);
  ////////////////////////////////////////////////////////////////////////
  lmcd_state_type st_r, st_nxt;
  logic [7:0] buf_r [`LMCD_BUF_DEPTH];
  logic [7:0] buf_nxt [`LMCD_BUF_DEPTH];
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] pid_r, pid_nxt;
  logic rx_r, rx_nxt;
  logic [7:0] nad_r, nad_nxt;
  logic sleep_allow_r, sleep_allow_nxt;
  logic [15:0] tgt_r, tgt_nxt;
  logic tload_r, tload_nxt;
  lmcd_motion_param_type par_r, par_nxt;
  logic pload_r, pload_nxt;
  logic sleep_r, sleep_nxt;
  logic stop_r, stop_nxt;
  logic sent_r, sent_nxt;
  logic stent_r, stent_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ck_ok;
  logic halt_start;
  logic halt_done;
  logic [15:0] halt_pos;
  logic [5:0] fid;
  logic dual_go, param_go, sleep_go;
  logic slot1_hit, slot2_hit;
  logic [15:0] first_target_position, second_target_position, ppos;

  function automatic logic [15:0] sext11(input logic [10:0] v);
    return {{5{v[10]}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // sleep frames use the classic sum, all others include the pid byte
  lmcd_cksum u_cksum (
    .clk(clk),
    .srst(srst),
    .start(lnk_frame_start),
    .init((lnk_pid[5:0] == `LMCD_SLEEP_ID) ? 8'h00 : lnk_pid),
    .byte_valid(lnk_byte_valid && rx_r),
    .byte_in(lnk_byte),
    .ok(ck_ok)
  );

  lmcd_halt u_halt (
    .clk(clk),
    .srst(srst),
    .start(halt_start),
    .motion_active(motion_active),
    .actual_position(actual_position),
    .halt_active(gentle_halt),
    .done(halt_done),
    .hold_position(halt_pos)
  );

  ////////////////////////////////////////////////////////////////////////
  // frame decode, valid only in the frame end cycle
  assign fid = pid_r[5:0];
  assign first_target_position = {buf_r[`LMCD_D_P1H], buf_r[`LMCD_D_P1L]};
  assign second_target_position = {buf_r[`LMCD_D_P2H], buf_r[`LMCD_D_P2L]};
  assign ppos = {buf_r[`LMCD_P_PH], buf_r[`LMCD_P_PL]};
  assign slot1_hit = buf_r[`LMCD_D_FIRST_NODE_ADDRESS] != `LMCD_BCAST_NAD
    && buf_r[`LMCD_D_FIRST_NODE_ADDRESS] == nad_r;
  assign slot2_hit = buf_r[`LMCD_D_SECOND_NODE_ADDRESS] != `LMCD_BCAST_NAD
    && buf_r[`LMCD_D_SECOND_NODE_ADDRESS] == nad_r;
  assign dual_go = lnk_frame_end && rx_r && ck_ok && fid == DUAL_ID
    && cnt_r == `LMCD_LEN_DUAL && !positioning_ignored;
  // filler byte is not checked, a damaged one fails the sum anyway
  assign param_go = lnk_frame_end && rx_r && ck_ok && fid == PARAM_ID
    && cnt_r == `LMCD_LEN_PARAM && buf_r[`LMCD_P_CMD] == `LMCD_CMD_POSPARAM
    && (buf_r[`LMCD_P_NAD] == `LMCD_BCAST_NAD
    || buf_r[`LMCD_P_NAD] == nad_r);
  // no address compare and no check of the trailing bytes
  assign sleep_go = lnk_frame_end && rx_r && ck_ok && fid == `LMCD_SLEEP_ID
    && cnt_r == `LMCD_LEN_SLEEP
    && buf_r[`LMCD_S_CMD] == `LMCD_SLEEP_CMD;
  assign halt_start = sleep_go && st_r == LMCD_ST_IDLE && motion_active
    && secondary_position == `LMCD_SECONDARY_POSITION_OFF;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    pid_nxt = pid_r;
    rx_nxt = rx_r;
    tgt_nxt = tgt_r;
    tload_nxt = 1'b0;
    par_nxt = par_r;
    pload_nxt = 1'b0;
    sleep_nxt = sleep_r;
    stop_nxt = stop_r;
    sent_nxt = 1'b0;
    stent_nxt = 1'b0;
    if (lnk_frame_start) begin
      rx_nxt = 1'b1;
      cnt_nxt = 4'h0;
      pid_nxt = lnk_pid;
    end else if (lnk_frame_end) begin
      rx_nxt = 1'b0;
    end else if (lnk_byte_valid && rx_r && cnt_r < `LMCD_LEN_SLEEP) begin
      buf_nxt[cnt_r] = lnk_byte;
      cnt_nxt = cnt_r + 4'h1;
    end
    if (dual_go && slot1_hit) begin
      tgt_nxt = first_target_position;
      tload_nxt = 1'b1;
    end else if (dual_go && slot2_hit) begin
      tgt_nxt = second_target_position;
      tload_nxt = 1'b1;
    end
    if (param_go) begin
      tgt_nxt = ppos;
      tload_nxt = 1'b1;
      par_nxt.vmax = buf_r[`LMCD_P_VEL][7:4];
      par_nxt.vmin = buf_r[`LMCD_P_VEL][3:0];
      par_nxt.stall_thr = buf_r[`LMCD_P_THR][7:4];
      par_nxt.accel = buf_r[`LMCD_P_THR][3:0];
      pload_nxt = 1'b1;
    end
    if (tload_nxt) begin
      sleep_nxt = 1'b0;
      stop_nxt = 1'b0;
    end
    unique case (st_r)
      LMCD_ST_IDLE: begin
        if (sleep_go) begin
          if (motion_active && secondary_position != `LMCD_SECONDARY_POSITION_OFF) begin
            tgt_nxt = sext11(secondary_position);
            tload_nxt = 1'b1;
          end
          if (halt_start) begin
            st_nxt = LMCD_ST_HALT;
          end else if (sleep_allow_r) begin
            sleep_nxt = 1'b1;
            sent_nxt = 1'b1;
          end else begin
            stop_nxt = 1'b1;
            stent_nxt = 1'b1;
          end
        end
      end
      LMCD_ST_HALT: begin
        // positioning during the halt is overridden by the hold point
        if (halt_done) begin
          st_nxt = LMCD_ST_IDLE;
          tgt_nxt = halt_pos;
          tload_nxt = 1'b1;
          sleep_nxt = sleep_allow_r;
          sent_nxt = sleep_allow_r;
          stop_nxt = !sleep_allow_r;
          stent_nxt = !sleep_allow_r;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nad_nxt = nad_r;
    sleep_allow_nxt = sleep_allow_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr && reg_addr == `LMCD_REG_CTRL) begin
      nad_nxt = reg_wdata[`LMCD_CTRL_NAD_LSB +: 8];
      sleep_allow_nxt = reg_wdata[`LMCD_CTRL_SLEEP_BIT];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `LMCD_REG_CTRL: rdata_nxt = {23'h000000, sleep_allow_r, nad_r};
        `LMCD_REG_STATUS: rdata_nxt = {28'h0000000, gentle_halt, stop_r, sleep_r,
          motion_active};
        `LMCD_REG_PARAM: rdata_nxt = {16'h0000, par_r};
        `LMCD_REG_TARGET: rdata_nxt = {16'h0000, tgt_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= LMCD_ST_IDLE;
      for (int i = 0; i < `LMCD_BUF_DEPTH; i++) begin
        buf_r[i] <= 8'h00;
      end
      cnt_r <= 4'h0;
      pid_r <= 8'h00;
      rx_r <= 1'b0;
      nad_r <= `LMCD_NAD_RST;
      sleep_allow_r <= `LMCD_SLEEP_ALLOW_RST;
      tgt_r <= 16'h0000;
      tload_r <= 1'b0;
      par_r <= '0;
      pload_r <= 1'b0;
      sleep_r <= 1'b0;
      stop_r <= 1'b0;
      sent_r <= 1'b0;
      stent_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      buf_r <= buf_nxt;
      cnt_r <= cnt_nxt;
      pid_r <= pid_nxt;
      rx_r <= rx_nxt;
      nad_r <= nad_nxt;
      sleep_allow_r <= sleep_allow_nxt;
      tgt_r <= tgt_nxt;
      tload_r <= tload_nxt;
      par_r <= par_nxt;
      pload_r <= pload_nxt;
      sleep_r <= sleep_nxt;
      stop_r <= stop_nxt;
      sent_r <= sent_nxt;
      stent_r <= stent_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign target_position = tgt_r;
  assign target_load = tload_r;
  assign motion_params = par_r;
  assign params_load = pload_r;
  assign sleep_enter = sent_r;
  assign stopped_enter = stent_r;

  ////////////////////////////////////////////////////////////////////////
  AST_DUAL_SLOT2: assert property (@(posedge clk) disable iff (srst)
    dual_go && !slot1_hit && slot2_hit && !param_go && !sleep_go
    |=> target_load && target_position == $past(second_target_position))
    else $error("second slot target not applied");
  AST_DUAL_IGNORED: assert property (@(posedge clk) disable iff (srst)
    lnk_frame_end && positioning_ignored && fid == DUAL_ID && st_r == LMCD_ST_IDLE
    && !sleep_go |=> !target_load)
    else $error("dual goto acted while positioning ignored");
  AST_DUAL_FOREIGN: assert property (@(posedge clk) disable iff (srst)
    lnk_frame_end && fid == DUAL_ID && !slot1_hit && !slot2_hit
    && st_r == LMCD_ST_IDLE |=> !target_load && $stable(target_position))
    else $error("foreign dual frame changed target");
  AST_PARAM_FIELDS: assert property (@(posedge clk) disable iff (srst)
    param_go |=> params_load && motion_params.vmax == $past(buf_r[`LMCD_P_VEL][7:4])
    && motion_params.accel == $past(buf_r[`LMCD_P_THR][3:0]))
    else $error("motion parameters not loaded from frame");
  AST_PARAM_ADDR: assert property (@(posedge clk) disable iff (srst)
    params_load |-> $past(buf_r[`LMCD_P_NAD]) == `LMCD_BCAST_NAD
    || $past(buf_r[`LMCD_P_NAD]) == $past(nad_r))
    else $error("param frame for another node accepted");
  AST_BAD_SUM: assert property (@(posedge clk) disable iff (srst)
    lnk_frame_end && !ck_ok && st_r == LMCD_ST_IDLE
    |=> !target_load && !params_load && !sleep_enter && !stopped_enter)
    else $error("frame with bad checksum acted upon");
  AST_SLEEP_SECONDARY_POSITION: assert property (@(posedge clk) disable iff (srst)
    sleep_go && st_r == LMCD_ST_IDLE && motion_active
    && secondary_position != `LMCD_SECONDARY_POSITION_OFF
    |=> target_load && target_position == sext11($past(secondary_position)))
    else $error("secondary position not copied on sleep");
  AST_SLEEP_HALT: assert property (@(posedge clk) disable iff (srst)
    halt_start |=> gentle_halt && !sleep_enter && !stopped_enter)
    else $error("gentle halt not started before sleep");
  AST_SLEEP_ALLOWED: assert property (@(posedge clk) disable iff (srst)
    sleep_enter |-> $past(sleep_allow_r) && sleep_r)
    else $error("sleep entered while not allowed");
  AST_STOPPED: assert property (@(posedge clk) disable iff (srst)
    sleep_go && st_r == LMCD_ST_IDLE && !halt_start && !sleep_allow_r
    |=> stopped_enter && !sleep_enter)
    else $error("stopped state not entered");
endmodule // lmcd_decoder
`default_nettype wire

// ===== verif/lmcd_lin_master.sv
// lin master model driving frames into the decoder link port
`default_nettype none
module lmcd_lin_master (
  input wire logic clk,
  output logic frame_start,
  output logic [7:0] pid,
  output logic byte_valid,
  output logic [7:0] data,
  output logic frame_end
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_start = 1'b0;
    pid = 8'h00;
    byte_valid = 1'b0;
    data = 8'h00;
    frame_end = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bad flips checksum bit 0 so a refused frame differs by one bit only
  task automatic send(input logic [5:0] id, input logic [7:0] d [8], input int n,
                      input logic bad);
    logic [8:0] sum;
    logic [7:0] p;
    logic [7:0] b;
    p = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    sum = (id == 6'h3C) ? 9'h000 : {1'b0, p};
    @(posedge clk);
    frame_start <= 1'b1;
    pid <= p;
    for (int i = 0; i <= n; i++) begin
      if (i < n) begin
        b = d[i];
        sum = {1'b0, sum[7:0]} + {1'b0, b};
        sum = {1'b0, sum[7:0]} + {8'h00, sum[8]};
      end else begin
        b = ~sum[7:0] ^ {7'h00, bad};
      end
      @(posedge clk);
      frame_start <= 1'b0;
      pid <= ~p;
      byte_valid <= 1'b1;
      data <= b;
    end
    @(posedge clk);
    byte_valid <= 1'b0;
    data <= ~b;
    frame_end <= 1'b1;
    @(posedge clk);
    frame_end <= 1'b0;
  endtask
endmodule // lmcd_lin_master
`default_nettype wire

// ===== verif/lmcd_decoder_tb_top.sv
// self-checking bench for the motion command decoder
`default_nettype none
module lmcd_decoder_tb_top import lmcd_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic fs, bv, fe;
  logic [7:0] pid, lb;
  logic pos_ign = 1'b0;
  logic moving = 1'b0;
  logic [15:0] act_pos = 16'h0000;
  logic [10:0] sec_pos = 11'h400;
  logic [15:0] tgt;
  logic tl, pl, gh, se, ste;
  lmcd_motion_param_type mp;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n_tl, n_pl, n_se, n_st;
  logic [15:0] last_tgt, last_mp;
  always #12.5 clk = ~clk;
  lmcd_decoder lmcd_decoder_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lnk_frame_start(fs), .lnk_pid(pid), .lnk_byte_valid(bv), .lnk_byte(lb),
    .lnk_frame_end(fe), .positioning_ignored(pos_ign), .motion_active(moving),
    .actual_position(act_pos), .secondary_position(sec_pos), .target_position(tgt),
    .target_load(tl), .motion_params(mp), .params_load(pl), .gentle_halt(gh),
    .sleep_enter(se), .stopped_enter(ste));
  lmcd_lin_master lmcd_lin_master_inst (.clk(clk), .frame_start(fs), .pid(pid),
    .byte_valid(bv), .data(lb), .frame_end(fe));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (tl === 1'b1) begin
      n_tl++;
      last_tgt = tgt;
    end
    if (pl === 1'b1) begin
      n_pl++;
      last_mp = mp;
    end
    if (se === 1'b1) n_se++;
    if (ste === 1'b1) n_st++;
    if (cyc == 8000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // read data stand only in this cycle, look once they have settled
    #1;
    check(reg_rdata, exp);
  endtask
  task automatic clr();
    n_tl = 0;
    n_pl = 0;
    n_se = 0;
    n_st = 0;
  endtask
  task automatic frm(input logic [5:0] id, input logic [7:0] d [8], input int n,
                     input logic bad, input int exp_tl, input logic [15:0] exp_tgt);
    clr();
    lmcd_lin_master_inst.send(id, d, n, bad);
    repeat (3) @(posedge clk);
    check(n_tl, exp_tl);
    if (exp_tl > 0) check(last_tgt, exp_tgt);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    reg_read(4'h0, 32'h0000_0101);
    reg_read(4'h2, 32'h0000_0000);
    reg_read(4'hC, 32'h0000_0000);
  endtask
  task automatic t_dual();
    frm(6'h05, '{8'h7F, 8'h34, 8'h92, 8'h01, 8'hCD, 8'hAB, 8'h00, 8'h00},
        6, 0, 1, 16'hABCD);
    frm(6'h05, '{8'h01, 8'hFE, 8'hFF, 8'h7F, 8'h11, 8'h22, 8'h00, 8'h00},
        6, 0, 1, 16'hFFFE);
    frm(6'h05, '{8'h02, 8'h10, 8'h00, 8'h03, 8'h20, 8'h00, 8'h00, 8'h00}, 6, 0, 0, 16'h0);
    frm(6'h05, '{8'h01, 8'h10, 8'h00, 8'h01, 8'h20, 8'h00, 8'h00, 8'h00}, 6, 1, 0, 16'h0);
    frm(6'h05, '{8'h01, 8'h10, 8'h00, 8'h03, 8'h20, 8'h00, 8'h00, 8'h00}, 5, 0, 0, 16'h0);
    pos_ign <= 1'b1;
    frm(6'h05, '{8'h01, 8'h10, 8'h00, 8'h03, 8'h20, 8'h00, 8'h00, 8'h00}, 6, 0, 0, 16'h0);
    pos_ign <= 1'b0;
  endtask
  task automatic t_param();
    frm(6'h00, '{8'h01, 8'h2F, 8'h34, 8'h82, 8'h5A, 8'h9C, 8'hFF, 8'h00},
        7, 0, 1, 16'h8234);
    check(last_mp, 16'h5A9C);
    check(n_pl, 1);
    frm(6'h00, '{8'h7F, 8'h2F, 8'h11, 8'h00, 8'h21, 8'h43, 8'hFF, 8'h00},
        7, 0, 1, 16'h0011);
    check(n_pl, 1);
    frm(6'h00, '{8'h01, 8'h2E, 8'h55, 8'h00, 8'h77, 8'h77, 8'hFF, 8'h00}, 7, 0, 0, 16'h0);
    check(n_pl, 0);
    frm(6'h00, '{8'h02, 8'h2F, 8'h55, 8'h00, 8'h77, 8'h77, 8'hFF, 8'h00}, 7, 0, 0, 16'h0);
    check(n_pl, 0);
    frm(6'h00, '{8'h01, 8'h2F, 8'h55, 8'h00, 8'h77, 8'h77, 8'hFF, 8'h00}, 7, 1, 0, 16'h0);
    check(n_pl, 0);
    reg_read(4'h8, 32'h0000_2143);
    reg_read(4'hC, 32'h0000_0011);
  endtask
  task automatic t_sleep();
    reg_write(4'h0, 32'h0000_0122);
    frm(6'h3C, '{8'h00, 8'h12, 8'h00, 8'h34, 8'hFF, 8'h00, 8'h56, 8'h78}, 8, 0, 0, 16'h0);
    check(n_se, 1);
    reg_read(4'h4, 32'h0000_0002);
    frm(6'h3C, '{8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF}, 8, 0, 0, 16'h0);
    check(n_se, 0);
    reg_write(4'h0, 32'h0000_0022);
    frm(6'h3C, '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF}, 8, 0, 0, 16'h0);
    check(n_st, 1);
    check(n_se, 0);
    reg_read(4'h4, 32'h0000_0006);
    reg_write(4'h0, 32'h0000_0122);
    frm(6'h3C, '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF}, 8, 1, 0, 16'h0);
    check(n_se, 0);
    check(n_st, 0);
  endtask
  task automatic t_moving();
    moving <= 1'b1;
    sec_pos <= 11'h5AB;
    frm(6'h3C, '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF},
        8, 0, 1, 16'hFDAB);
    check(n_se, 1);
    sec_pos <= 11'h400;
    clr();
    lmcd_lin_master_inst.send(6'h3C, '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF},
                              8, 1'b0);
    @(posedge clk);
    check(gh, 1'b1);
    check(n_se, 0);
    act_pos <= 16'h7E31;
    moving <= 1'b0;
    repeat (6) @(posedge clk);
    check(n_tl, 1);
    check(last_tgt, 16'h7E31);
    check(n_se, 1);
    check(gh, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_dual();
    t_param();
    t_sleep();
    t_moving();
    print_verdict();
  end
endmodule // lmcd_decoder_tb_top
`default_nettype wire
